// ---- logic/umspi_ctrl.sv ----
// master-only spi unit with avalon-mm register slave
//
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "umspi_cfg.svh"

module umspi_ctrl
  import umspi_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire umspi_avm_req_t avmReq,
  output umspi_avm_rsp_t avmRsp,
  input wire logic serialIn,
  input wire logic globalIrqEnable,
  input wire logic txCompleteIrqAck,
  output umspi_pins_t pins,
  output umspi_irq_t irq
);

  umspi_state_t st;
  umspi_state_t next_st;

  function automatic logic modeIsMaster(input logic [1:0] mode);
    modeIsMaster = (mode == `UMSPI_MODE_MSPI);
  endfunction

  function automatic logic outBit(input logic [7:0] shift, input logic lsbFirst);
    outBit = lsbFirst ? shift[0] : shift[7];
  endfunction

  function automatic logic [7:0] shiftOut(input logic [7:0] shift, input logic lsbFirst);
    shiftOut = lsbFirst ? {1'b1, shift[7:1]} : {shift[6:0], 1'b1};
  endfunction

  function automatic logic [7:0] shiftIn(input logic [7:0] shift, input logic lsbFirst,
                                        input logic bitIn);
    shiftIn = lsbFirst ? {bitIn, shift[7:1]} : {shift[6:0], bitIn};
  endfunction

  logic master;
  logic busy;
  logic accept;
  logic wrAcc;
  logic rdAcc;
  logic rxc;
  logic udre;
  logic [7:0] regA;
  logic [7:0] regB;
  logic [7:0] regC;
  logic [31:0] readValue;

  always_comb begin
    master = modeIsMaster(st.mode);
    busy = (st.phase == UMSPI_SHIFT);
    accept = (avmReq.read | avmReq.write) & st.ack;
    wrAcc = accept & avmReq.write;
    rdAcc = accept & avmReq.read;
    rxc = (st.rxCount != 2'h0);
    udre = ~st.txBufFull;
    // low bits hold no error flags in this mode
    regA = {rxc, st.txDone, udre, 5'h00};
    regB = {st.rxIrqEn, st.txIrqEn, st.emptyIrqEn, st.rxEn, st.txEn & ~st.txOffPending,
            `UMSPI_B_FIXED};
    regC = {st.mode, 3'h0, st.bitOrder, st.cpha, st.cpol};
    case (avmReq.address)
      `UMSPI_OFF_DATA: readValue = {24'h000000, st.rxQueue[0]};
      `UMSPI_OFF_CSA: readValue = {24'h000000, regA};
      `UMSPI_OFF_CSB: readValue = {24'h000000, regB};
      `UMSPI_OFF_CSC: readValue = {24'h000000, regC};
      `UMSPI_OFF_BAUD: readValue = {20'h00000, st.baud};
      default: readValue = 32'h00000000;
    endcase
  end

  // one wait state: the request is answered at the second edge it is seen
  always_comb begin
    avmRsp.waitrequest = (avmReq.read | avmReq.write) & ~st.ack;
    avmRsp.readdata = st.rdata;
  end

  always_comb begin
    pins.serialClock = st.sclk;
    pins.serialClockOe = master & st.txEn;
    pins.serialOut = st.mosi;
    pins.serialOutOe = master & st.txEn;
    pins.rxPinOwned = master & st.rxEn;
    irq.rxCompleteIrq = st.rxIrqEn & globalIrqEnable & rxc;
    irq.txCompleteIrq = st.txIrqEn & globalIrqEnable & st.txDone;
    irq.bufferEmptyIrq = st.emptyIrqEn & globalIrqEnable & udre;
  end

  logic tick;
  logic leading;
  logic frameEnd;
  logic loadNow;
  logic pop;

  always_comb begin
    next_st = st;
    tick = 1'b0;
    leading = 1'b0;
    frameEnd = 1'b0;
    loadNow = 1'b0;
    pop = 1'b0;

    // first stage feeds only the second
    next_st.misoMeta = serialIn;
    next_st.misoSync = st.misoMeta;

    // bus handshake
    next_st.ack = (avmReq.read | avmReq.write) & ~st.ack;
    if ((avmReq.read | avmReq.write) & ~st.ack) begin
      next_st.rdata = readValue;
    end

    // half-bit timer, rate from divisor only
    if (busy) begin
      if (st.baudCnt == 12'h000) begin
        tick = 1'b1;
        next_st.baudCnt = st.baud;
      end else begin
        next_st.baudCnt = st.baudCnt - 12'h001;
      end
    end

    if (busy && tick) begin
      leading = ~st.edgeCnt[0];
      next_st.sclk = ~st.sclk;
      next_st.edgeCnt = st.edgeCnt + 4'h1;
      if (leading == ~st.cpha) begin
        next_st.rxShift = shiftIn(st.rxShift, st.bitOrder, st.misoSync);
      end else if (st.edgeCnt != `UMSPI_LAST_EDGE) begin
        next_st.mosi = outBit(st.txShift, st.bitOrder);
        next_st.txShift = shiftOut(st.txShift, st.bitOrder);
      end
      if (st.edgeCnt == `UMSPI_LAST_EDGE) begin
        frameEnd = 1'b1;
        next_st.phase = UMSPI_IDLE;
        next_st.sclk = st.cpol;
        next_st.mosi = 1'b1;
      end
    end

    if (!busy) begin
      next_st.sclk = st.cpol;
    end

    // receive queue: newest character dropped when both levels hold data and none is read in the same cycle
    // last trailing-edge sample is already taken above; no extra shift here
    pop = rdAcc && (avmReq.address == `UMSPI_OFF_DATA) && rxc;
    if (pop) begin
      next_st.rxQueue[0] = st.rxQueue[1];
      next_st.rxCount = st.rxCount - 2'h1;
    end
    if (frameEnd && st.rxEn) begin
      if (pop || st.rxCount == 2'h0) begin
        next_st.rxQueue[pop ? st.rxCount - 2'h1 : 2'h0] = next_st.rxShift;
        next_st.rxCount = pop ? st.rxCount : 2'h1;
      end else if (st.rxCount != `UMSPI_RXQ_DEPTH) begin
        next_st.rxQueue[1] = next_st.rxShift;
        next_st.rxCount = 2'h2;
      end
    end

    // transmit buffer and shift register
    if (wrAcc && avmReq.address == `UMSPI_OFF_DATA && st.txEn && ~st.txBufFull) begin
      next_st.txBuf = avmReq.writedata[7:0];
      next_st.txBufFull = 1'b1;
    end
    loadNow = st.txBufFull && master && st.txEn && (!busy || frameEnd);
    if (loadNow) begin
      next_st.phase = UMSPI_SHIFT;
      next_st.txBufFull = 1'b0;
      next_st.baudCnt = st.baud;
      next_st.edgeCnt = 4'h0;
      next_st.sclk = st.cpol;
      if (!st.cpha) begin
        next_st.mosi = outBit(st.txBuf, st.bitOrder);
        next_st.txShift = shiftOut(st.txBuf, st.bitOrder);
      end else begin
        next_st.txShift = st.txBuf;
      end
    end

    // transmit complete: clear by write-one or by service, a new set wins
    if ((wrAcc && avmReq.address == `UMSPI_OFF_CSA && avmReq.writedata[`UMSPI_A_TXC]) ||
        txCompleteIrqAck) begin
      next_st.txDone = 1'b0;
    end
    if (frameEnd && !loadNow) begin
      next_st.txDone = 1'b1;
    end

    // control writes; reserved bits are ignored
    if (wrAcc && avmReq.address == `UMSPI_OFF_CSB) begin
      next_st.rxIrqEn = avmReq.writedata[`UMSPI_B_RXCIE];
      next_st.txIrqEn = avmReq.writedata[`UMSPI_B_TXCIE];
      next_st.emptyIrqEn = avmReq.writedata[`UMSPI_B_BUFFER_EMPTY_IRQ_ENABLE];
      next_st.rxEn = avmReq.writedata[`UMSPI_B_RXEN];
      if (avmReq.writedata[`UMSPI_B_TXEN]) begin
        next_st.txEn = 1'b1;
        next_st.txOffPending = 1'b0;
      end else begin
        next_st.txOffPending = st.txEn;
      end
    end
    if (!next_st.rxEn) begin
      next_st.rxCount = 2'h0;
    end
    // disable takes hold only once nothing is left to send
    if (st.txOffPending && !busy && !st.txBufFull) begin
      next_st.txEn = 1'b0;
      next_st.txOffPending = 1'b0;
    end
    if (wrAcc && avmReq.address == `UMSPI_OFF_CSC) begin
      // a single write sets mode, order, phase and polarity together
      next_st.mode = avmReq.writedata[`UMSPI_C_MODE_HI:`UMSPI_C_MODE_LO];
      next_st.bitOrder = avmReq.writedata[`UMSPI_C_ORDER];
      next_st.cpha = avmReq.writedata[`UMSPI_C_CPHA];
      next_st.cpol = avmReq.writedata[`UMSPI_C_CPOL];
    end
    if (wrAcc && avmReq.address == `UMSPI_OFF_BAUD) begin
      next_st.baud = avmReq.writedata[11:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      st <= '0;
      st.phase <= UMSPI_IDLE;
      st.mode <= 2'(`UMSPI_RST_C >> `UMSPI_C_MODE_LO);
      st.bitOrder <= 1'(`UMSPI_RST_C >> `UMSPI_C_ORDER);
      st.cpha <= 1'(`UMSPI_RST_C >> `UMSPI_C_CPHA);
      st.cpol <= 1'(`UMSPI_RST_C >> `UMSPI_C_CPOL);
      st.sclk <= 1'(`UMSPI_RST_C >> `UMSPI_C_CPOL);
      st.baud <= `UMSPI_RST_BAUD;
      st.mosi <= 1'b1;
      st.misoMeta <= 1'b1;
      st.misoSync <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

endmodule

// ---- logic/umspi_cfg.svh ----
// offsets, field positions, reset values and timing figures of the master spi unit
`ifndef UMSPI_CFG_SVH
`define UMSPI_CFG_SVH
`define UMSPI_OFF_DATA 3'h0
`define UMSPI_OFF_CSA 3'h1
`define UMSPI_OFF_CSB 3'h2
`define UMSPI_OFF_CSC 3'h3
`define UMSPI_OFF_BAUD 3'h4
`define UMSPI_A_RXC 7
`define UMSPI_A_TXC 6
`define UMSPI_A_UDRE 5
`define UMSPI_B_RXCIE 7
`define UMSPI_B_TXCIE 6
`define UMSPI_B_BUFFER_EMPTY_IRQ_ENABLE 5
`define UMSPI_B_RXEN 4
`define UMSPI_B_TXEN 3
`define UMSPI_B_FIXED 3'h6
`define UMSPI_C_MODE_HI 7
`define UMSPI_C_MODE_LO 6
`define UMSPI_C_ORDER 2
`define UMSPI_C_CPHA 1
`define UMSPI_C_CPOL 0
`define UMSPI_MODE_MSPI 2'h3
`define UMSPI_RST_B 8'h06
`define UMSPI_RST_C 8'h00
`define UMSPI_RST_BAUD 12'h000
`define UMSPI_LAST_EDGE 4'hf
`define UMSPI_RXQ_DEPTH 2'h2
`endif

// ---- logic/umspi_pkg.sv ----
// types of the master spi unit
package umspi_pkg;

  typedef enum logic [1:0] {
    UMSPI_IDLE = 2'b01,
    UMSPI_SHIFT = 2'b10
  } umspi_phase_t;

  typedef struct packed {
    logic [2:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } umspi_avm_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } umspi_avm_rsp_t;

  typedef struct packed {
    logic serialClock;
    logic serialClockOe;
    logic serialOut;
    logic serialOutOe;
    logic rxPinOwned;
  } umspi_pins_t;

  typedef struct packed {
    logic rxCompleteIrq;
    logic txCompleteIrq;
    logic bufferEmptyIrq;
  } umspi_irq_t;

  typedef struct packed {
    umspi_phase_t phase;
    logic ack;
    logic [31:0] rdata;
    logic rxIrqEn;
    logic txIrqEn;
    logic emptyIrqEn;
    logic rxEn;
    logic txEn;
    logic txOffPending;
    logic [1:0] mode;
    logic bitOrder;
    logic cpha;
    logic cpol;
    logic [11:0] baud;
    logic [11:0] baudCnt;
    logic [3:0] edgeCnt;
    logic sclk;
    logic mosi;
    logic [7:0] txBuf;
    logic txBufFull;
    logic [7:0] txShift;
    logic [7:0] rxShift;
    logic [1:0][7:0] rxQueue;
    logic [1:0] rxCount;
    logic txDone;
    logic misoMeta;
    logic misoSync;
  } umspi_state_t;

endpackage

// ---- test/umspi_ctrl_props.sv ----
// assertion checker for the master spi unit
`timescale 1ns/10ps
module umspi_ctrl_props
  import umspi_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire umspi_avm_req_t avmReq,
  input wire umspi_avm_rsp_t avmRsp,
  input wire logic serialIn,
  input wire logic globalIrqEnable,
  input wire logic txCompleteIrqAck,
  input wire umspi_pins_t pins,
  input wire umspi_irq_t irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic req;
  logic rdOk;
  assign req = avmReq.read | avmReq.write;
  assign rdOk = avmReq.read & !avmRsp.waitrequest;
  property p_irq_rx; irq.rxCompleteIrq |-> globalIrqEnable; endproperty
  a_irq_rx: assert property (p_irq_rx) else $error("rx irq while masked");
  property p_irq_tx; irq.txCompleteIrq |-> globalIrqEnable; endproperty
  a_irq_tx: assert property (p_irq_tx) else $error("tx irq while masked");
  property p_irq_empty; irq.bufferEmptyIrq |-> globalIrqEnable; endproperty
  a_irq_empty: assert property (p_irq_empty) else $error("empty irq while masked");
  property p_wait_first; $rose(req) |-> avmRsp.waitrequest; endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait state");
  property p_wait_one; req && avmRsp.waitrequest |=> !avmRsp.waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait state too long");
  property p_a_resv; rdOk && avmReq.address == 3'h1 |-> avmRsp.readdata[4:0] == 5'h00; endproperty
  a_a_resv: assert property (p_a_resv) else $error("error flags not zero");
  property p_b_resv; rdOk && avmReq.address == 3'h2 |-> avmRsp.readdata[2:0] == 3'h6; endproperty
  a_b_resv: assert property (p_b_resv) else $error("ctrl B low bits wrong");
  property p_oe_pair; pins.serialClockOe == pins.serialOutOe; endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("clock and data enables differ");
  property p_out_idle; !pins.serialOutOe |-> pins.serialOut; endproperty
  a_out_idle: assert property (p_out_idle) else $error("data line not idle high");
  // release only once the clock has stopped
  property p_oe_release; $fell(pins.serialOutOe) |-> $stable(pins.serialClock); endproperty
  a_oe_release: assert property (p_oe_release) else $error("output released mid frame");
  c_rx_irq: cover property (irq.rxCompleteIrq);
  c_tx_ack: cover property (irq.txCompleteIrq ##1 txCompleteIrqAck ##1 !irq.txCompleteIrq);
  c_release: cover property ($fell(pins.serialOutOe));
endmodule

bind umspi_ctrl umspi_ctrl_props chk_u (.clock(clock), .nrst(nrst), .avmReq(avmReq),
  .avmRsp(avmRsp), .serialIn(serialIn), .globalIrqEnable(globalIrqEnable),
  .txCompleteIrqAck(txCompleteIrqAck), .pins(pins), .irq(irq));

// ---- test/umspi_slave_model.sv ----
// spi slave model answering each frame with a rising count
`timescale 1ns/10ps
module umspi_slave_model (
  input wire logic serialClock,
  input wire logic serialClockOe,
  output logic serialIn
);
  logic [7:0] nextByte = 8'h11;
  logic [7:0] shifter = 8'h11;
  int bitCnt = 0;
  assign serialIn = shifter[7];
  // mode 0 only: setup on falling edges, msb first
  always @(negedge serialClock) begin
    if (serialClockOe) begin
      if (bitCnt == 7) begin
        nextByte = nextByte + 8'h01;
        shifter = nextByte;
        bitCnt = 0;
      end else begin
        shifter = {shifter[6:0], ~shifter[0]};
        bitCnt++;
      end
    end
  end
endmodule

// ---- test/umspi_ctrl_tb.sv ----
// self-checking bench for the master spi unit
`timescale 1ns/10ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin errors++; \
  $display("unexpected %s expected %h seen %h", n, e, s); end end
module umspi_ctrl_tb import umspi_pkg::*;;
  logic clock;
  logic nrst;
  logic globalIrqEnable;
  logic txCompleteIrqAck;
  logic serialIn;
  umspi_avm_req_t avmReq;
  umspi_avm_rsp_t avmRsp;
  umspi_pins_t pins;
  umspi_irq_t irq;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [15:0] mosiCap = 16'h0000;
  logic [7:0] q;
  umspi_ctrl dut_u (.clock(clock), .nrst(nrst), .avmReq(avmReq), .avmRsp(avmRsp),
    .serialIn(serialIn), .globalIrqEnable(globalIrqEnable),
    .txCompleteIrqAck(txCompleteIrqAck), .pins(pins), .irq(irq));
  umspi_slave_model slave_u (.serialClock(pins.serialClock),
    .serialClockOe(pins.serialClockOe), .serialIn(serialIn));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // mode 0 sample edge
  always @(posedge pins.serialClock) mosiCap <= {mosiCap[14:0], pins.serialOut};
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end
  task automatic finish_test;
    if (errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    avmReq <= '{address: a, read: !w, write: w, writedata: {24'h000000, d}};
    do @(posedge clock); while (avmRsp.waitrequest !== 1'b0);
    q = avmRsp.readdata[7:0];
    avmReq.read <= 1'b0;
    avmReq.write <= 1'b0;
  endtask
  task automatic wait_txc;
    do bus(1'b0, 3'h1, 8'h00); while (q[6] !== 1'b1);
  endtask
  task automatic t_reset;
    bus(1'b0, 3'h1, 8'h00); `CHK("ctrl A", 8'h20, q)
    bus(1'b0, 3'h2, 8'h00); `CHK("ctrl B", 8'h06, q)
    bus(1'b0, 3'h3, 8'h00); `CHK("ctrl C", 8'h00, q)
    bus(1'b0, 3'h5, 8'h00); `CHK("unmapped", 8'h00, q)
  endtask
  task automatic t_setup;
    bus(1'b1, 3'h3, 8'hc0);
    bus(1'b1, 3'h2, 8'h18);
    bus(1'b1, 3'h4, 8'h03);
    `CHK("out enable", 1'b1, pins.serialOutOe)
    `CHK("in owned", 1'b1, pins.rxPinOwned)
  endtask
  task automatic t_duplex;
    bus(1'b1, 3'h0, 8'h3c);
    bus(1'b1, 3'h0, 8'h81);
    bus(1'b0, 3'h1, 8'h00); `CHK("empty busy", 1'b0, q[5])
    wait_txc();
    `CHK("mosi bits", 16'h3c81, mosiCap)
    `CHK("ctrl A done", 8'he0, q)
    bus(1'b0, 3'h0, 8'h00); `CHK("rx first", 8'h11, q)
    bus(1'b0, 3'h0, 8'h00); `CHK("rx second", 8'h12, q)
    bus(1'b0, 3'h1, 8'h00); `CHK("ctrl A read", 8'h60, q)
  endtask
  task automatic t_irq;
    globalIrqEnable <= 1'b1;
    bus(1'b1, 3'h2, 8'h78);
    @(posedge clock);
    `CHK("tx irq", 1'b1, irq.txCompleteIrq)
    `CHK("empty irq", 1'b1, irq.bufferEmptyIrq)
    `CHK("rx irq", 1'b0, irq.rxCompleteIrq)
    txCompleteIrqAck <= 1'b1;
    @(posedge clock) txCompleteIrqAck <= 1'b0;
    @(posedge clock);
    `CHK("tx irq ack", 1'b0, irq.txCompleteIrq)
    globalIrqEnable <= 1'b0;
    @(posedge clock);
    `CHK("empty masked", 1'b0, irq.bufferEmptyIrq)
  endtask
  task automatic t_overflow;
    globalIrqEnable <= 1'b1;
    bus(1'b1, 3'h2, 8'h98);
    bus(1'b1, 3'h0, 8'h01);
    bus(1'b1, 3'h0, 8'h02);
    wait_txc();
    bus(1'b1, 3'h1, 8'h40);
    bus(1'b0, 3'h1, 8'h00); `CHK("txc cleared", 1'b0, q[6])
    bus(1'b1, 3'h0, 8'h03);
    wait_txc();
    `CHK("rx irq", 1'b1, irq.rxCompleteIrq)
    bus(1'b0, 3'h0, 8'h00); `CHK("kept old", 8'h13, q)
    bus(1'b0, 3'h0, 8'h00); `CHK("newest dropped", 8'h14, q)
  endtask
  // phase one: setup on rising, sample on falling
  task automatic t_mode1;
    bus(1'b1, 3'h3, 8'hc2);
    bus(1'b1, 3'h1, 8'h40);
    bus(1'b1, 3'h0, 8'ha5);
    bus(1'b1, 3'h0, 8'h5a);
    wait_txc();
    `CHK("mode1 mosi", 16'ha55a, mosiCap)
    bus(1'b0, 3'h0, 8'h00); `CHK("mode1 rx", 8'h16, q)
    bus(1'b1, 3'h2, 8'h08);
    bus(1'b0, 3'h1, 8'h00); `CHK("flushed", 1'b0, q[7])
  endtask
  task automatic t_lsb_release;
    bus(1'b1, 3'h3, 8'hc4);
    bus(1'b1, 3'h1, 8'h40);
    bus(1'b1, 3'h0, 8'h03);
    bus(1'b1, 3'h2, 8'h00);
    `CHK("held enable", 1'b1, pins.serialOutOe)
    wait_txc();
    `CHK("lsb first", 8'hc0, mosiCap[7:0])
    `CHK("released", 1'b0, pins.serialOutOe)
    bus(1'b1, 3'h3, 8'hc1);
    repeat (2) @(posedge clock);
    `CHK("clock idle", 1'b1, pins.serialClock)
  endtask
  initial begin
    nrst = 1'b0;
    avmReq = '0;
    globalIrqEnable = 1'b0;
    txCompleteIrqAck = 1'b0;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    t_reset();
    t_setup();
    t_duplex();
    t_irq();
    t_overflow();
    t_mode1();
    t_lsb_release();
    finish_test();
  end
endmodule
